// [bsp_defines.svh]
// Constants for the board serial port logic
`ifndef BSP_DEFINES_SVH
`define BSP_DEFINES_SVH

// ==========================================================
// Port decode
`define BSP_DEC_BASE     6'h3B
`define BSP_OFS_DATA     8'hEC
`define BSP_OFS_CTRL     8'hED

// ==========================================================
// Command word bits
`define BSP_CMD_TX_EN    0
`define BSP_CMD_ERR_RST  4
`define BSP_CMD_INT_RST  6

// ==========================================================
// Status byte bits
`define BSP_ST_TXHF      0
`define BSP_ST_RXW       1
`define BSP_ST_TXAE      2
`define BSP_ST_PERR      3
`define BSP_ST_OVR       4
`define BSP_ST_FRM       5

// ==========================================================
// Rate dividers as terminal counts, then minimum character length and one-stop code
`define BSP_DIV15_TOP    4'hE
`define BSP_DIV16_TOP    4'hF
`define BSP_F16_TOP      6'h0F
`define BSP_F64_TOP      6'h3F
`define BSP_F16_HALF     6'h07
`define BSP_F64_HALF     6'h1F
`define BSP_MIN_BITS     4'h5
`define BSP_STOP_ONE     2'h1

`endif

// [bsp_pkg.sv]
// Types for the board serial port logic
package bsp_pkg;

   // ==========================================================
   // Mode and command words, laid out as on the data bus
   typedef struct packed {
      logic [1:0] stop;
      logic       even;
      logic       par_en;
      logic [1:0] len;
      logic [1:0] fac;
   } bsp_mode_t;

   typedef struct packed {
      logic hunt;
      logic int_reset;
      logic req_send;
      logic err_reset;
      logic send_break;
      logic rx_enable;
      logic term_ready;
      logic tx_enable_bit;
   } bsp_cmd_t;

   // ==========================================================
   // States and jumper codes
   typedef enum logic [1:0] {
      BSP_TX_IDLE = 2'b01,
      BSP_TX_SEND = 2'b10
   } bsp_tx_st_t;

   typedef enum logic [2:0] {
      BSP_RX_IDLE  = 3'b001,
      BSP_RX_START = 3'b010,
      BSP_RX_BITS  = 3'b100
   } bsp_rx_st_t;

   typedef enum logic [1:0] {
      BSP_IRQ_INHIBIT = 2'b00,
      BSP_IRQ_RXW     = 2'b01,
      BSP_IRQ_TXHF    = 2'b10,
      BSP_IRQ_TXAE    = 2'b11
   } bsp_route_t;

   // ==========================================================
   // Module state
   typedef struct packed {
      logic [3:0] div15;
      logic [3:0] div_a;
      logic [3:0] div_b;
      logic       tick;
   } bsp_baud_st_t;

   typedef struct packed {
      logic       mode_done;
      bsp_mode_t  mode;
      bsp_cmd_t   cmd;
      bsp_route_t route;
      logic [1:0] tap;
      logic       wr_n;
      logic       rd_n;
      logic [2:0] rxd_s;
      logic       rxd_v;
      logic       rxd_prev;
      logic [2:0] osc_s;
      logic       osc_v;
      logic       osc_tick;
      logic [7:0] thr;
      logic       thr_full;
      bsp_tx_st_t tx_st;
      logic [11:0] tx_sh;
      logic [3:0] tx_left;
      logic [5:0] tx_cnt;
      bsp_rx_st_t rx_st;
      logic [7:0] rx_sh;
      logic [3:0] rx_idx;
      logic [5:0] rx_cnt;
      logic       rx_pacc;
      logic       rx_perr;
      logic [7:0] rbr;
      logic       rx_wait;
      logic       perr;
      logic       ovr;
      logic       frm;
      logic       txd;
      logic       dtr_n;
      logic       irq_n;
      logic       rxw;
      logic       thf;
      logic       tae;
      logic [7:0] dout;
      logic       doe;
   } bsp_state_t;

endpackage

// [bsp_baud_gen.sv]
// Bit-rate clock chain: divide by 15, then two divide-by-16 stages
`timescale 1ns/1ns
`default_nettype none
`include "bsp_defines.svh"

module bsp_baud_gen
   import bsp_pkg::*;
(
   // Clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   // Oscillator edges and tap jumper
   input  wire logic       i_osc_tick,
   input  wire logic [1:0] i_tap,
   // Selected bit-rate tick
   output logic            o_baud_tick
);

   bsp_baud_st_t s_q;
   bsp_baud_st_t s_d;
   logic         p15;
   logic         pa;
   logic         pb;

   // ==========================================================
   // Counter chain
   assign p15 = i_osc_tick && (s_q.div15 == `BSP_DIV15_TOP);
   assign pa  = p15 && (s_q.div_a == `BSP_DIV16_TOP);
   assign pb  = pa && (s_q.div_b == `BSP_DIV16_TOP);

   always_comb begin
      s_d = s_q;
      if (i_osc_tick) begin
         s_d.div15 = p15 ? 4'h0 : s_q.div15 + 4'h1;
      end
      if (p15) begin
         s_d.div_a = s_q.div_a + 4'h1;
      end
      if (pa) begin
         s_d.div_b = s_q.div_b + 4'h1;
      end
      // Jumper picks one tap; unused code falls back to the first
      case (i_tap)
         2'h1:    s_d.tick = pa;
         2'h2:    s_d.tick = pb;
         default: s_d.tick = p15;
      endcase
      if (i_rst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge i_mclk) begin
      s_q <= s_d;
   end

   assign o_baud_tick = s_q.tick;

   // ==========================================================
   // Checks
   property p_div15_range;
      @(posedge i_mclk) disable iff (i_rst)
      s_q.div15 <= `BSP_DIV15_TOP;
   endproperty
   a_div15_range: assert property (p_div15_range)
      else $error("first stage left its 15-count range");

   property p_stage_carry;
      @(posedge i_mclk) disable iff (i_rst)
      p15 |=> s_q.div_a == $past(s_q.div_a) + 4'h1;
   endproperty
   a_stage_carry: assert property (p_stage_carry)
      else $error("second stage missed its count");

endmodule
`default_nettype wire

// [bsp_serial_port.sv]
// Serial port: bus decode, programmable UART, interrupt routing
`timescale 1ns/1ns
`default_nettype none
`include "bsp_defines.svh"

module bsp_serial_port
   import bsp_pkg::*;
(
   // Clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_rst,
   // Processor I/O bus
   input  wire logic [7:0] i_addr,
   input  wire logic       i_io_write_n,
   input  wire logic       i_io_read_n,
   input  wire logic [7:0] i_data,
   output logic      [7:0] o_data,
   output logic            o_data_oe,
   // Oscillator and jumpers
   input  wire logic       i_oscillator_source,
   input  wire logic [1:0] i_irq_route,
   input  wire logic [1:0] i_baud_tap,
   // Serial line
   input  wire logic       i_rxd,
   output logic            o_txd,
   output logic            o_term_ready_n,
   // Status pins and interrupt
   output logic            o_rx_char_waiting,
   output logic            o_tx_holding_free,
   output logic            o_tx_all_empty,
   output logic            o_serial_irq_n
);

   bsp_state_t s_q;
   bsp_state_t s_d;
   logic       sel;
   logic       wr_ev;
   logic       rd_ev;
   logic       baud_tick;
   logic [7:0] status;

   // ==========================================================
   // Helpers
   function automatic logic [3:0] nbits(input logic [1:0] len);
      nbits = `BSP_MIN_BITS + {2'b00, len};
   endfunction

   function automatic logic [5:0] fac_top(input logic [1:0] fac,
                                          input logic half);
      case (fac)
         2'h2:    fac_top = half ? `BSP_F16_HALF : `BSP_F16_TOP;
         2'h3:    fac_top = half ? `BSP_F64_HALF : `BSP_F64_TOP;
         default: fac_top = 6'h00;
      endcase
   endfunction

   // Frame as {bit count, shift pattern}, start bit in bit 0
   function automatic logic [15:0] frame(input bsp_mode_t m,
                                         input logic [7:0] d);
      logic [11:0] sh;
      logic [3:0]  nb;
      logic [3:0]  cnt;
      logic        p;
      sh  = 12'hFFF;
      nb  = nbits(m.len);
      p   = ~m.even;
      sh[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(nb)) begin
            sh[i + 1] = d[i];
            p = p ^ d[i];
         end
      end
      if (m.par_en) begin
         sh[nb + 4'h1] = p;
      end
      cnt = 4'h1 + nb + {3'b000, m.par_en};
      cnt = cnt + ((m.stop == `BSP_STOP_ONE) ? 4'h1 : 4'h2);
      frame = {cnt, sh};
   endfunction

   // ==========================================================
   // Bus decode
   assign sel   = (i_addr[7:2] == `BSP_DEC_BASE);
   assign wr_ev = sel && !i_io_write_n && s_q.wr_n;
   assign rd_ev = sel && !i_io_read_n && s_q.rd_n;

   // Status bits 0 to 2 mirror the status pins, bits 3 to 5 hold the error flags
   always_comb begin
      status = 8'h00;
      status[`BSP_ST_TXHF] = s_q.thf;
      status[`BSP_ST_RXW]  = s_q.rxw;
      status[`BSP_ST_TXAE] = s_q.tae;
      status[`BSP_ST_PERR] = s_q.perr;
      status[`BSP_ST_OVR]  = s_q.ovr;
      status[`BSP_ST_FRM]  = s_q.frm;
   end

   // ==========================================================
   // Bit-rate chain
   bsp_baud_gen u_baud (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .i_osc_tick  (s_q.osc_tick),
      .i_tap       (s_q.tap),
      .o_baud_tick (baud_tick)
   );

   // ==========================================================
   // Next state
   always_comb begin
      logic [15:0] fr;
      logic [3:0]  nb;
      logic        bit_ev;
      logic        txsrc;
      fr     = 16'h0000;
      nb     = nbits(s_q.mode.len);
      bit_ev = 1'b0;
      txsrc  = 1'b0;
      s_d    = s_q;

      // Strobe history, jumpers and pin synchronisers
      s_d.wr_n  = i_io_write_n;
      s_d.rd_n  = i_io_read_n;
      s_d.route = bsp_route_t'(i_irq_route);
      s_d.tap   = i_baud_tap;
      s_d.rxd_s = {s_q.rxd_s[1:0], i_rxd};
      if (s_q.rxd_s[2] == s_q.rxd_s[1]) begin
         s_d.rxd_v = s_q.rxd_s[2];
      end
      s_d.rxd_prev = s_q.rxd_v;
      s_d.osc_s = {s_q.osc_s[1:0], i_oscillator_source};
      if (s_q.osc_s[2] == s_q.osc_s[1]) begin
         s_d.osc_v = s_q.osc_s[2];
      end
      s_d.osc_tick = s_d.osc_v && !s_q.osc_v;

      // Transmitter; runs before the bus so a same-cycle write
      // lands in the holding register after the old byte leaves
      case (s_q.tx_st)
         BSP_TX_IDLE: begin
            s_d.txd = !s_q.cmd.send_break;
            if (s_q.thr_full && s_q.cmd.tx_enable_bit) begin
               fr = frame(s_q.mode, s_q.thr);
               s_d.tx_sh    = fr[11:0];
               s_d.tx_left  = fr[15:12];
               s_d.tx_cnt   = fac_top(s_q.mode.fac, 1'b0);
               s_d.thr_full = 1'b0;
               s_d.txd      = 1'b0;
               s_d.tx_st    = BSP_TX_SEND;
            end
         end
         BSP_TX_SEND: begin
            if (baud_tick) begin
               if (s_q.tx_cnt == 6'h00) begin
                  bit_ev     = 1'b1;
                  s_d.tx_cnt = fac_top(s_q.mode.fac, 1'b0);
               end else begin
                  s_d.tx_cnt = s_q.tx_cnt - 6'h01;
               end
            end
            if (bit_ev) begin
               s_d.tx_sh   = {1'b1, s_q.tx_sh[11:1]};
               s_d.tx_left = s_q.tx_left - 4'h1;
               s_d.txd     = s_d.tx_sh[0];
               if (s_q.tx_left == 4'h1) begin
                  s_d.txd   = 1'b1;
                  s_d.tx_st = BSP_TX_IDLE;
               end
            end
         end
         default: s_d.tx_st = BSP_TX_IDLE;
      endcase

      // Bus writes
      if (wr_ev) begin
         if (i_addr[0]) begin
            if (!s_q.mode_done) begin
               s_d.mode      = bsp_mode_t'(i_data);
               s_d.mode_done = 1'b1;
            end else begin
               s_d.cmd = bsp_cmd_t'(i_data);
               if (i_data[`BSP_CMD_ERR_RST]) begin
                  s_d.perr = 1'b0;
                  s_d.ovr  = 1'b0;
                  s_d.frm  = 1'b0;
               end
               if (i_data[`BSP_CMD_INT_RST]) begin
                  s_d.mode_done = 1'b0;
                  s_d.cmd       = '0;
               end
            end
         end else begin
            s_d.thr      = i_data;
            s_d.thr_full = 1'b1;
         end
      end

      // Bus reads; data is latched on the strobe's first cycle
      s_d.doe = sel && !i_io_read_n;
      if (rd_ev) begin
         s_d.dout = i_addr[0] ? status : s_q.rbr;
         if (!i_addr[0]) begin
            s_d.rx_wait = 1'b0;
         end
      end

      // Receiver; after the read so a new character wins
      bit_ev = 1'b0;
      if (baud_tick && (s_q.rx_st != BSP_RX_IDLE)) begin
         if (s_q.rx_cnt == 6'h00) begin
            bit_ev     = 1'b1;
            s_d.rx_cnt = fac_top(s_q.mode.fac, 1'b0);
         end else begin
            s_d.rx_cnt = s_q.rx_cnt - 6'h01;
         end
      end
      case (s_q.rx_st)
         BSP_RX_IDLE: begin
            if (s_q.rxd_prev && !s_q.rxd_v) begin
               s_d.rx_cnt = fac_top(s_q.mode.fac, 1'b1);
               s_d.rx_st  = BSP_RX_START;
            end
         end
         BSP_RX_START: begin
            if (bit_ev) begin
               // At x16 and x64 a glitch shorter than half a bit is dropped
               s_d.rx_st   = s_q.rxd_v ? BSP_RX_IDLE : BSP_RX_BITS;
               s_d.rx_idx  = 4'h0;
               s_d.rx_pacc = 1'b0;
               s_d.rx_perr = 1'b0;
            end
         end
         BSP_RX_BITS: begin
            if (bit_ev) begin
               s_d.rx_idx = s_q.rx_idx + 4'h1;
               if (s_q.rx_idx < nb) begin
                  s_d.rx_sh   = {s_q.rxd_v, s_q.rx_sh[7:1]};
                  s_d.rx_pacc = s_q.rx_pacc ^ s_q.rxd_v;
               end else if (s_q.mode.par_en && (s_q.rx_idx == nb)) begin
                  s_d.rx_perr = s_q.rx_pacc ^ s_q.rxd_v ^ ~s_q.mode.even;
               end else begin
                  s_d.rbr = 8'(s_q.rx_sh >> (4'h8 - nb));
                  s_d.ovr = s_d.ovr | s_d.rx_wait;
                  s_d.perr = s_d.perr | s_q.rx_perr;
                  s_d.frm = s_d.frm | !s_q.rxd_v;
                  s_d.rx_wait = 1'b1;
                  s_d.rx_st   = BSP_RX_IDLE;
               end
            end
         end
         default: s_d.rx_st = BSP_RX_IDLE;
      endcase

      // Pins, all registered from the next state
      s_d.dtr_n = !s_d.cmd.term_ready;
      s_d.rxw = s_d.cmd.rx_enable && s_d.rx_wait;
      s_d.thf = s_d.cmd.tx_enable_bit && !s_d.thr_full;
      s_d.tae = s_d.cmd.tx_enable_bit && !s_d.thr_full
                && (s_d.tx_st == BSP_TX_IDLE);
      case (s_d.route)
         BSP_IRQ_RXW:  txsrc = s_d.rxw;
         BSP_IRQ_TXHF: txsrc = s_d.thf;
         BSP_IRQ_TXAE: txsrc = s_d.tae;
         default:      txsrc = 1'b0;
      endcase
      s_d.irq_n = !txsrc;

      // Synchronous reset wins over everything
      if (i_rst) begin
         s_d          = '0;
         s_d.wr_n     = 1'b1;
         s_d.rd_n     = 1'b1;
         s_d.rxd_s    = 3'h7;
         s_d.rxd_v    = 1'b1;
         s_d.rxd_prev = 1'b1;
         s_d.tx_st    = BSP_TX_IDLE;
         s_d.rx_st    = BSP_RX_IDLE;
         s_d.txd      = 1'b1;
         s_d.dtr_n    = 1'b1;
         s_d.irq_n    = 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      s_q <= s_d;
   end

   // ==========================================================
   // Outputs
   assign o_data            = s_q.dout;
   assign o_data_oe         = s_q.doe;
   assign o_txd             = s_q.txd;
   assign o_term_ready_n    = s_q.dtr_n;
   assign o_rx_char_waiting = s_q.rxw;
   assign o_tx_holding_free = s_q.thf;
   assign o_tx_all_empty    = s_q.tae;
   assign o_serial_irq_n    = s_q.irq_n;

   // ==========================================================
   // Checks
   sequence s_ctrl_wr;
      wr_ev && i_addr[0];
   endsequence

   sequence s_data_wr;
      wr_ev && !i_addr[0];
   endsequence

   property p_first_is_mode;
      @(posedge i_mclk) disable iff (i_rst)
      s_ctrl_wr and !s_q.mode_done
      |=> s_q.mode_done && (s_q.mode == $past(i_data));
   endproperty
   a_first_is_mode: assert property (p_first_is_mode)
      else $error("first control write not taken as mode");

   property p_later_is_cmd;
      @(posedge i_mclk) disable iff (i_rst)
      s_ctrl_wr and s_q.mode_done and !i_data[`BSP_CMD_INT_RST]
      |=> s_q.cmd == $past(i_data) && $stable(s_q.mode);
   endproperty
   a_later_is_cmd: assert property (p_later_is_cmd)
      else $error("later control write not taken as command");

   property p_data_load;
      @(posedge i_mclk) disable iff (i_rst)
      s_data_wr |=> s_q.thr_full && (s_q.thr == $past(i_data))
                    && !o_tx_holding_free;
   endproperty
   a_data_load: assert property (p_data_load)
      else $error("data write did not fill holding register");

   property p_tx_gate;
      @(posedge i_mclk) disable iff (i_rst)
      !s_q.cmd.tx_enable_bit |-> !o_tx_holding_free && !o_tx_all_empty;
   endproperty
   a_tx_gate: assert property (p_tx_gate)
      else $error("transmit indication while transmit disabled");

   property p_rx_gate;
      @(posedge i_mclk) disable iff (i_rst)
      o_rx_char_waiting |-> s_q.cmd.rx_enable && s_q.rx_wait;
   endproperty
   a_rx_gate: assert property (p_rx_gate)
      else $error("receive-waiting without enable and character");

   property p_inhibit;
      @(posedge i_mclk) disable iff (i_rst)
      s_q.route == BSP_IRQ_INHIBIT |-> o_serial_irq_n;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("interrupt raised while inhibited");

   property p_data_read;
      @(posedge i_mclk) disable iff (i_rst)
      rd_ev && !i_addr[0] && (s_q.rx_st != BSP_RX_BITS)
      |=> o_data_oe && (o_data == $past(s_q.rbr)) && !s_q.rx_wait;
   endproperty
   a_data_read: assert property (p_data_read)
      else $error("data read wrong or waiting flag kept");

   property p_status_read;
      @(posedge i_mclk) disable iff (i_rst)
      rd_ev && i_addr[0] |=> o_data == $past(status);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("status read returned wrong byte");

   property p_tx_off_irq;
      @(posedge i_mclk) disable iff (i_rst)
      s_ctrl_wr and s_q.mode_done and !i_data[`BSP_CMD_TX_EN]
      and (s_q.route inside {BSP_IRQ_TXHF, BSP_IRQ_TXAE})
      |=> o_serial_irq_n ##1 o_serial_irq_n;
   endproperty
   a_tx_off_irq: assert property (p_tx_off_irq)
      else $error("interrupt kept after transmitter disabled");

   property p_idle_holds_irq;
      @(posedge i_mclk) disable iff (i_rst)
      (s_q.route == BSP_IRQ_TXAE) && (i_irq_route == 2'h3)
      && o_tx_all_empty && !wr_ev
      |=> !o_serial_irq_n;
   endproperty
   a_idle_holds_irq: assert property (p_idle_holds_irq)
      else $error("idle transmitter dropped its interrupt");

endmodule
`default_nettype wire

// [bsp_term_model.sv]
// Serial terminal model facing the port's serial pins
`timescale 1ns/1ns
`default_nettype none

module bsp_term_model #(
   parameter int BIT = 960
) (
   // Clock
   input  wire logic i_mclk,
   // Serial pins
   input  wire logic i_txd,
   output logic      o_rxd
);
   // ==========================================================
   // Receive side, sampled at mid-bit
   logic [7:0] rx_byte = 8'h00;
   int         rx_cnt = 0;
   logic [7:0] sh;
   initial o_rxd = 1'b1;
   always begin
      @(negedge i_txd);
      repeat (BIT / 2) @(posedge i_mclk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge i_mclk);
         sh[i] = i_txd;
      end
      repeat (BIT) @(posedge i_mclk);
      rx_byte = sh;
      rx_cnt++;
   end

   // ==========================================================
   // Send side; line idles marking, as a real terminal
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_mclk);
         o_rxd <= f[i];
         repeat (BIT - 1) @(posedge i_mclk);
      end
   endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Testbench for the board serial port logic
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   import bsp_pkg::*;
   // ==========================================================
   // Signals
   logic       clk = 0, rst = 1, wr_n = 1, rd_n = 1, osc = 0, rxd;
   logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, q, st;
   logic [1:0] route = 2'h0;
   logic       oe, txd, dtr_n, rxw, thf, tae, irq_n;
   int         err_total = 0, tests_run = 0, cyc = 0, n;
   logic [7:0] exp_q[$];
   wire logic [7:0] pins = {2'b00, irq_n, dtr_n, txd, rxw, thf, tae};

   always #25 clk = ~clk;
   // Osc tick every 4 cycles, so one bit at x16 is 960 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc % 2 == 0) osc <= ~osc;
      if (cyc == 40000) begin
         err_total++;
         final_report();
      end
   end

   bsp_serial_port DUT (.i_mclk(clk), .i_rst(rst), .i_addr(addr),
      .i_io_write_n(wr_n), .i_io_read_n(rd_n), .i_data(wdat),
      .o_data(rdat), .o_data_oe(oe), .i_oscillator_source(osc),
      .i_irq_route(route), .i_baud_tap(2'h0), .i_rxd(rxd), .o_txd(txd),
      .o_term_ready_n(dtr_n), .o_rx_char_waiting(rxw),
      .o_tx_holding_free(thf), .o_tx_all_empty(tae),
      .o_serial_irq_n(irq_n));
   bsp_term_model #(.BIT(960)) term (.i_mclk(clk), .i_txd(txd),
      .o_rxd(rxd));

   // ==========================================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr_n <= 1'b0;
      @(posedge clk);
      wr_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_n <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      rd_n <= 1'b1;
      #1 d = rdat;
      chk({7'h00, oe}, {7'h00, a[7:2] == 6'h3B});
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      n = $urandom(36);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1 chk(pins, 8'h38);
      wr(8'hED, 8'h4E);
      wr(8'hEF, 8'h17);
      chk(pins, 8'h2B);
      rd(8'hED, st);
      chk(st, 8'h05);
      rd(8'hE9, st);
      for (int r = 0; r < 4; r++) begin
         @(posedge clk);
         route <= 2'(r);
         repeat (3) @(posedge clk);
         #1 chk({7'h00, irq_n}, {7'h00, r < 2});
      end
      @(posedge clk);
      route <= 2'h1;
      q = 8'($urandom);
      exp_q.push_back(q);
      n = term.rx_cnt;
      wr(8'hEC, q);
      chk({7'h00, tae}, 8'h00);
      for (int i = 0; i < 12000 && term.rx_cnt == n; i++) @(posedge clk);
      chk(term.rx_byte, exp_q.pop_front());
      q = 8'($urandom);
      term.send(q);
      for (int i = 0; i < 100 && rxw !== 1'b1; i++) @(posedge clk);
      repeat (2) @(posedge clk);
      #1 chk({7'h00, irq_n}, 8'h00);
      rd(8'hED, st);
      chk(st, 8'h07);
      rd(8'hEE, st);
      chk(st, q);
      @(posedge clk);
      #1 chk({6'h00, irq_n, rxw}, 8'h02);
      @(posedge clk);
      route <= 2'h2;
      wr(8'hED, 8'h16);
      chk(pins, 8'h28);
      wr(8'hED, 8'h40);
      chk(pins, 8'h38);
      wr(8'hED, 8'h4E);
      wr(8'hED, 8'h17);
      chk(pins, 8'h0B);
      final_report();
   end
endmodule
`default_nettype wire
